// ### rtl/pis_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
module pis_cpu_end (
   input wire logic clk,
   input wire logic rst_n,                      // also panel master clear
   pis_link_if.cpu link,
   // cpu side events and timing
   input wire logic [pis_pkg::CPU_EVENTS-1:0] cpuEvent,  // level 0..3 event pulses
   input wire logic [3:0] chassisRequest,       // levels 4..7 internal sources
   input wire logic [3:0] chassisClaimed,       // 1: level 4+n used internally
   input wire logic instructionEnd,             // end of instruction pulse
   input wire logic interruptDone,              // cpu finished the sequence
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // accepted interrupt
   output logic interruptStart,                 // one-cycle pulse on accept
   output logic [pis_pkg::ADDR_W-1:0] vectorAddress, // list word char address
   output logic [pis_pkg::ADDR_W-1:0] trapAddress     // trap list word char address
);
   import pis_pkg::*;

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   logic enabled;               // interrupt system allowed
   logic inhibited;             // set on accept until allowed again
   logic [5:0] currentLevelRegister; // running program level
   logic [3:0] eventLatch;      // latched cpu events, levels 0..3
   logic [5:0] sampledExt;      // last sampled external code
   logic [15:0] gapCount;       // cycles since last external sample
   logic [5:0] codeSync1;       // first sync stage of the code
   logic [5:0] codeSync2;       // second sync stage
   logic apbWrite;              // apb write access phase
   logic [31:0] wd;             // shorthand for write data

   assign apbWrite = psel && penable && pwrite;
   assign wd = pwdata;

   // true when level lvl ranks above program level prog
   function automatic logic outranks(input logic [5:0] lvl, input logic [5:0] prog);
      outranks = lvl < prog;
   endfunction

   // ---------------------------------------------
   // synchronise the bus code, it arrives from other cards
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         codeSync1 <= LEVEL_IDLE;
         codeSync2 <= LEVEL_IDLE;
      end else begin
         codeSync1 <= link.encodedRequestLines;
         codeSync2 <= codeSync1;
      end
   end

   // ---------------------------------------------
   // cpu event latches, set wins over clear
   // ---------------------------------------------
   genvar g;
   generate
      for (g = 0; g < CPU_EVENTS; g++) begin : gEvt
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               eventLatch[g] <= 1'b0;
            end else if (cpuEvent[g]) begin
               eventLatch[g] <= 1'b1;
            end else if (apbWrite && paddr == APB_CTRL && wd[CTRL_CLEAR + g]) begin
               eventLatch[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ---------------------------------------------
   // internal priority: levels 0..7, claimed 4..7 only
   // ---------------------------------------------
   logic [7:0] intReq;   // internal request vector
   logic intAny;         // any internal pending
   logic [5:0] intBest;  // best internal level
   always_comb begin
      intReq = {chassisRequest & chassisClaimed, eventLatch};
      intAny = |intReq;
      intBest = LEVEL_IDLE;
      for (int i = INT_LEVELS - 1; i >= 0; i--) begin
         if (intReq[i]) begin
            intBest = 6'(i);
         end
      end
   end

   // ---------------------------------------------
   // external sampling with 2 us spacing
   // ---------------------------------------------
   logic sampleOk;      // external sample allowed now
   logic extValid;      // sampled code is a legal external level
   assign sampleOk = instructionEnd && !intAny && gapCount >= 16'(SAMPLE_GAP_CYC);
   // a free level 4..7 only counts when not claimed internally
   assign extValid = codeSync2 >= LEVEL_EXT_MIN && codeSync2 <= LEVEL_EXT_MAX &&
      !(codeSync2 < 6'h08 && chassisClaimed[codeSync2[1:0]]);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gapCount <= 16'(SAMPLE_GAP_CYC); // first sample allowed at once
         link.externalSampleStrobe <= 1'b0;
         sampledExt <= LEVEL_IDLE;
      end else begin
         link.externalSampleStrobe <= sampleOk;
         if (sampleOk) begin
            gapCount <= 16'h0000;
            sampledExt <= extValid ? codeSync2 : LEVEL_IDLE;
         end else begin
            if (gapCount < 16'(SAMPLE_GAP_CYC)) begin
               gapCount <= gapCount + 16'h0001;
            end
            if (intAny) begin
               sampledExt <= LEVEL_IDLE; // stale sample discarded
            end
         end
      end
   end

   // ---------------------------------------------
   // acceptance: decided the cycle after instruction end
   // ---------------------------------------------
   logic decide;          // delayed instruction end
   logic [5:0] best;      // winning candidate
   always_comb begin
      best = intAny ? intBest : sampledExt;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         decide <= 1'b0;
      end else begin
         decide <= instructionEnd;
      end
   end

   // enable, inhibit and program level
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         enabled <= 1'b1;
         inhibited <= 1'b0;
         currentLevelRegister <= LEVEL_IDLE;
         interruptStart <= 1'b0;
         vectorAddress <= 16'h0000;
      end else begin
         interruptStart <= 1'b0;
         if (decide && enabled && !inhibited && best != LEVEL_IDLE &&
            outranks(best, currentLevelRegister)) begin
            inhibited <= 1'b1;
            currentLevelRegister <= best;
            interruptStart <= 1'b1;
            vectorAddress <= {9'h000, best, 1'b0};
         end else if (apbWrite && paddr == APB_CTRL) begin
            if (wd[CTRL_BLOCK]) begin
               enabled <= 1'b0;
            end else if (wd[CTRL_ALLOW]) begin
               enabled <= 1'b1;
               inhibited <= 1'b0;
            end
            if (wd[CTRL_LDLEV]) begin
               currentLevelRegister <= wd[CTRL_LEVEL +: 6]; // return to program level
            end
         end else if (interruptDone) begin
            inhibited <= inhibited; // held until software allows again
         end
      end
   end

   // trap list word, fixed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trapAddress <= TRAP_CHAR_ADDR;
      end else begin
         trapAddress <= TRAP_CHAR_ADDR;
      end
   end

   // ---------------------------------------------
   // unit control op: withdraw the level written to APB_ADDR
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link.unitControlOp <= 1'b0;
         link.unitControlLevel <= LEVEL_IDLE;
      end else begin
         link.unitControlOp <= apbWrite && paddr == APB_ADDR;
         if (apbWrite && paddr == APB_ADDR) begin
            link.unitControlLevel <= wd[5:0];
         end
      end
   end

   // ---------------------------------------------
   // apb slave: zero wait, reads registered in setup
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;   // answers in the first access cycle
         pslverr <= psel && !penable && paddr != APB_CTRL && paddr != APB_STAT && paddr != APB_ADDR;
         prdata <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               // packs to exactly 32 bits: requests at 25:18, sample 15:10, level 9:4
               APB_STAT: prdata <= {6'h00, intReq, 2'b00, sampledExt, currentLevelRegister,
                  2'b00, inhibited, enabled};
               APB_ADDR: prdata <= {16'h0000, vectorAddress};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ### shared/pis_pkg.sv
`default_nettype none
// ---------------------------------------------
// shared constants of the priority interrupt system
// ---------------------------------------------
package pis_pkg;
   localparam int LEVEL_W = 6;                       // level and bus code width
   localparam logic [5:0] LEVEL_IDLE = 6'h3F;        // 63: lowest program level, also "no request"
   localparam logic [5:0] LEVEL_EXT_MIN = 6'h04;     // lowest external level number
   localparam logic [5:0] LEVEL_EXT_MAX = 6'h3E;     // 62: highest external level number
   localparam int INT_LEVELS = 8;                    // internal levels 0..7
   localparam int CPU_EVENTS = 4;                    // levels 0..3 latched from cpu events
   localparam logic [5:0] LEVEL_POWER = 6'h00;       // power fail / restart
   localparam logic [5:0] LEVEL_OPERATOR = 6'h01;    // operator interrupt
   localparam logic [5:0] LEVEL_OPCODE = 6'h02;      // monitor link, stack overflow
   localparam logic [5:0] LEVEL_RTC = 6'h03;         // real time clock tick
   localparam int ADDR_W = 16;                       // bus character address width
   localparam logic [15:0] TRAP_CHAR_ADDR = 16'h007E; // word 63 list entry
   localparam int CLK_MHZ = 125;                     // clock rate
   localparam int SAMPLE_GAP_NS = 2000;              // least time between external samples
   localparam int SAMPLE_GAP_CYC = (SAMPLE_GAP_NS * CLK_MHZ + 999) / 1000; // rounded up
   localparam logic [7:0] APB_CTRL = 8'h00;          // control register offset
   localparam logic [7:0] APB_STAT = 8'h04;          // status register offset
   localparam logic [7:0] APB_ADDR = 8'h08;          // vector address register offset
   localparam int CTRL_ALLOW = 0;                    // write 1: allow requests
   localparam int CTRL_BLOCK = 1;                    // write 1: block all requests
   localparam int CTRL_CLEAR = 4;                    // bits 4..7: clear internal level n-4
   localparam int CTRL_LEVEL = 8;                    // bits 8..13: program level load
   localparam int CTRL_LDLEV = 14;                   // write 1: load program level
endpackage
`default_nettype wire

// ### shared/pis_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// encoded request lines between cpu and control units
// ---------------------------------------------
interface pis_link_if;
   logic [5:0] encodedRequestLines;   // highest pending external level, 63 = none
   logic externalSampleStrobe;        // high the cycle after the cpu took its sample of the synchronised lines
   logic unitControlOp;               // cpu orders a unit to withdraw
   logic [5:0] unitControlLevel;      // level addressed by unitControlOp
   modport cpu (input encodedRequestLines, output externalSampleStrobe, output unitControlOp,
      output unitControlLevel);
   modport unit (output encodedRequestLines, input externalSampleStrobe, input unitControlOp,
      input unitControlLevel);
endinterface
`default_nettype wire

// ### rtl/pis_unit_end.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// control unit group: jumper levels, requests, encoder
// ---------------------------------------------
module pis_unit_end #(
   parameter int UNITS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   pis_link_if.unit link,
   input wire logic [UNITS*6-1:0] unitLevel,       // jumper level per unit
   input wire logic [UNITS-1:0] wordReady,         // programmed channel word event
   input wire logic [UNITS-1:0] blockEnd,          // end of block status event
   output logic [UNITS-1:0] requestPending         // raised requests
);
   import pis_pkg::*;

   // ---------------------------------------------
   // request flags per unit
   // ---------------------------------------------
   genvar g;
   generate
      for (g = 0; g < UNITS; g++) begin : gUnit
         // raise on word or block end; the set wins over a withdraw
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               requestPending[g] <= 1'b0;
            end else if (wordReady[g] || blockEnd[g]) begin
               requestPending[g] <= 1'b1;
            end else if (link.unitControlOp && link.unitControlLevel == unitLevel[g*6 +: 6]) begin
               requestPending[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ---------------------------------------------
   // wired priority encoder: lowest level number wins
   // ---------------------------------------------
   logic [5:0] next_code; // best code this cycle
   always_comb begin
      next_code = LEVEL_IDLE;
      for (int i = 0; i < UNITS; i++) begin
         if (requestPending[i] && unitLevel[i*6 +: 6] < next_code) begin
            next_code = unitLevel[i*6 +: 6];
         end
      end
   end

   // registered drive onto the lines
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link.encodedRequestLines <= LEVEL_IDLE;
      end else begin
         link.encodedRequestLines <= next_code;
      end
   end
endmodule
`default_nettype wire

// ### testbench/pis_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// checker on the encoded request lines
// ---------------------------------------------
module pis_link_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] encodedRequestLines,
   input wire logic externalSampleStrobe,
   input wire logic unitControlOp,
   input wire logic [5:0] unitControlLevel
);
   import pis_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [8:0] sinceSample; // cycles since the last strobe, saturating
   logic [2:0] sinceOp;     // cycles since the last withdraw order
   // counters start saturated: the first strobe after reset is never flagged, a rise before any withdraw order is
   always_ff @(posedge clk) begin
      if (!rst_n) sinceSample <= 9'h1FF;
      else if (externalSampleStrobe) sinceSample <= 9'h000;
      else if (sinceSample != 9'h1FF) sinceSample <= sinceSample + 9'h001;
   end
   // separate concern: age of the last withdraw order
   always_ff @(posedge clk) begin
      if (!rst_n) sinceOp <= 3'h7;
      else if (unitControlOp) sinceOp <= 3'h0;
      else if (sinceOp != 3'h7) sinceOp <= sinceOp + 3'h1;
   end
   strobe_pulse_a: assert property (externalSampleStrobe |=> !externalSampleStrobe)
      else $error("sample strobe longer than one cycle");
   sample_gap_a: assert property (externalSampleStrobe |-> sinceSample >= 9'(SAMPLE_GAP_CYC - 1))
      else $error("external samples closer than the gap");
   reset_idle_a: assert property ($rose(rst_n) |-> encodedRequestLines == LEVEL_IDLE
      && !externalSampleStrobe && !unitControlOp) else $error("link not idle after reset");
   reset_clear_a: assert property ($rose(rst_n) |=> encodedRequestLines == LEVEL_IDLE)
      else $error("request seen too soon after reset");
   code_range_a: assert property (encodedRequestLines >= LEVEL_EXT_MIN)
      else $error("external code below level four");
   op_pulse_a: assert property (unitControlOp |=> !unitControlOp)
      else $error("withdraw order longer than one cycle");
   withdraw_code_a: assert property (unitControlOp && unitControlLevel == encodedRequestLines
      |-> ##[1:4] encodedRequestLines != unitControlLevel) else $error("withdrawn code still driven");
   no_rise_a: assert property (encodedRequestLines > $past(encodedRequestLines) |-> sinceOp <= 3'h3)
      else $error("lines dropped to a lower priority without withdraw");
   // main scenarios reached
   sample_c: cover property (externalSampleStrobe && encodedRequestLines != LEVEL_IDLE);
   withdraw_c: cover property (unitControlOp && unitControlLevel == encodedRequestLines);
   change_c: cover property (encodedRequestLines > $past(encodedRequestLines));
endmodule
`default_nettype wire

// ### testbench/pis_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pis_bench;
   import pis_pkg::*;
   // ---------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] cpuEvent = 4'h0;
   logic [3:0] chassisRequest = 4'h0; // no chassis request until testInternal raises level 4
   logic [3:0] chassisClaimed = 4'h1; // only level 4 claimed, so 5 is free for units
   logic instructionEnd = 1'b0;
   logic interruptDone = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, interruptStart;
   logic [15:0] vectorAddress, trapAddress;
   logic [23:0] unitLevel = {6'h05, 6'h3E, 6'h0A, 6'h28}; // units 3..0
   logic [3:0] wordReady = 4'h0, blockEnd = 4'h0, requestPending;
   int n_fail = 0, total_checks = 0;
   pis_link_if link();
   pis_cpu_end pis_cpu_end_i (.clk(clk), .rst_n(rst_n), .link(link), .cpuEvent(cpuEvent),
      .chassisRequest(chassisRequest), .chassisClaimed(chassisClaimed), .instructionEnd(instructionEnd),
      .interruptDone(interruptDone), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .interruptStart(interruptStart), .vectorAddress(vectorAddress), .trapAddress(trapAddress));
   pis_unit_end #(.UNITS(4)) pis_unit_end_i (.clk(clk), .rst_n(rst_n), .link(link), .unitLevel(unitLevel),
      .wordReady(wordReady), .blockEnd(blockEnd), .requestPending(requestPending));
   pis_link_asserts pis_link_asserts_i (.clk(clk), .rst_n(rst_n), .encodedRequestLines(link.encodedRequestLines),
      .externalSampleStrobe(link.externalSampleStrobe), .unitControlOp(link.unitControlOp),
      .unitControlLevel(link.unitControlLevel));
   always #4 clk = ~clk; // 125 MHz
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // apb cycle: request held until the rising edge that samples pready high, data taken there
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no local limit: only the watchdog ends a hung wait
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      // idle cycle so the next setup never reassigns psel in this time step
      @(posedge clk);
   endtask
   // end of instruction, then watch for the interrupt sequence start
   task automatic endInstr(input logic expGot, input logic [15:0] expVa);
      logic got;
      got = 1'b0;
      instructionEnd <= 1'b1;
      @(posedge clk);
      instructionEnd <= 1'b0;
      repeat (6) begin
         @(negedge clk);
         if (interruptStart === 1'b1) got = 1'b1;
      end
      @(posedge clk);
      check("accept", {31'h0, got}, {31'h0, expGot});
      if (expGot) check("vector", {16'h0, vectorAddress}, {16'h0, expVa});
   endtask
   task automatic pulseEvent(input int i);
      cpuEvent[i] <= 1'b1;
      @(posedge clk);
      cpuEvent <= 4'h0;
      @(posedge clk);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic testReset;
      apb(1'b0, APB_STAT, 32'h0);
      check("status", rdat & 32'h03FC_03F3, 32'h0000_03F1);
      check("trap", {16'h0, trapAddress}, {16'h0, TRAP_CHAR_ADDR});
      apb(1'b0, 8'h0C, 32'h0);
      check("unmapped", {31'h0, rerr}, 32'h1);
      $display("reset test done");
   endtask
   task automatic testInternal;
      for (int i = 0; i < 4; i++) begin
         pulseEvent(i);
         endInstr(1'b1, 16'(i << 1));
         apb(1'b0, APB_STAT, 32'h0);
         check("held", {31'h0, rdat[18+i]}, 32'h1);
         check("level", rdat & 32'h3F2, 32'(i << 4) | 32'h2);
         apb(1'b1, APB_CTRL, 32'h7F01 | 32'(1 << (4 + i))); // clear latch, back to 63
         apb(1'b0, APB_STAT, 32'h0);
         check("cleared", {24'h0, rdat[25:18]}, 32'h0);
      end
      apb(1'b1, APB_CTRL, 32'h4201); // program at level 2: equal request must wait
      pulseEvent(2);
      endInstr(1'b0, 16'h0);
      apb(1'b1, APB_CTRL, 32'h7F41);
      // chassis source on claimed level 4 is served as an internal request
      chassisRequest <= 4'h1;
      endInstr(1'b1, 16'h0008);
      chassisRequest <= 4'h0;
      apb(1'b1, APB_CTRL, 32'h7F01);
      $display("internal test done");
   endtask
   task automatic testBlock;
      apb(1'b1, APB_CTRL, 32'h2);
      pulseEvent(1);
      endInstr(1'b0, 16'h0);
      apb(1'b1, APB_CTRL, 32'h7F01);
      endInstr(1'b1, 16'h0002);
      apb(1'b1, APB_CTRL, 32'h7F21);
      $display("block test done");
   endtask
   // sample while blocked, then accept from that fresh sample and withdraw the unit
   task automatic serve(input logic [5:0] lvl);
      repeat (300) @(posedge clk);
      apb(1'b1, APB_CTRL, 32'h2);
      endInstr(1'b0, 16'h0);
      apb(1'b1, APB_CTRL, 32'h7F01);
      endInstr(1'b1, {9'h0, lvl, 1'b0});
      apb(1'b0, APB_ADDR, 32'h0);
      check("vector reg", rdat, {25'h0, lvl, 1'b0});
      apb(1'b1, APB_ADDR, {26'h0, lvl});
   endtask
   task automatic testExternal;
      wordReady <= 4'hB;
      blockEnd <= 4'h4;
      @(posedge clk);
      wordReady <= 4'h0;
      blockEnd <= 4'h0;
      repeat (2) @(posedge clk);
      check("raised", {28'h0, requestPending}, 32'hF);
      serve(6'h05);
      serve(6'h0A);
      serve(6'h28);
      serve(6'h3E);
      repeat (3) @(posedge clk);
      check("withdrawn", {28'h0, requestPending}, 32'h0);
      $display("external test done");
   endtask
   // master clear in mid-run: latch, unit request, block and level all return to reset state
   task automatic testClear;
      pulseEvent(0);
      apb(1'b1, APB_CTRL, 32'h4202); // blocked at program level 2
      wordReady <= 4'h1;
      @(posedge clk);
      wordReady <= 4'h0;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("pending", {28'h0, requestPending}, 32'h0);
      apb(1'b0, APB_STAT, 32'h0);
      check("cleared state", rdat & 32'h03FC_03F3, 32'h0000_03F1);
      $display("master clear test done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      testReset();
      testInternal();
      testBlock();
      testExternal();
      testClear();
      conclude();
   end
   // watchdog well beyond the some 1500 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end
endmodule
`default_nettype wire
